/* File: fes_pkg.sv */
// Package with command codes, unlock addresses and timing constants for the erase host
package fes_pkg;
  localparam logic [14:0] FES_UNLOCK_ADDR_A = 15'h5555;
  localparam logic [14:0] FES_UNLOCK_ADDR_B = 15'h2aaa;
  localparam logic [7:0]  FES_CODE_UNLOCK_A = 8'haa;
  localparam logic [7:0]  FES_CODE_UNLOCK_B = 8'h55;
  localparam logic [7:0]  FES_CODE_SETUP    = 8'h80;
  localparam logic [7:0]  FES_CODE_CHIP     = 8'h10;
  localparam logic [7:0]  FES_CODE_SECTOR   = 8'h30;
  localparam logic [7:0]  FES_CODE_RESET    = 8'hf0;
  localparam int          FES_CLK_MHZ       = 100;
  localparam int          FES_WINDOW_US     = 80;
  localparam int          FES_WINDOW_CYC    = FES_WINDOW_US * FES_CLK_MHZ;
  localparam int          FES_PHASE_CYC     = 2;
  localparam int          FES_SECTORS       = 8;
  localparam int          FES_SECT_LSB      = 16;
  localparam logic [3:0]  FES_REG_CTRL      = 4'h0;
  localparam logic [3:0]  FES_REG_SECT      = 4'h1;
  localparam logic [3:0]  FES_REG_STAT      = 4'h2;
  localparam logic [3:0]  FES_REG_DATA      = 4'h3;
  localparam int          FES_DP_BIT        = 7;
  localparam int          FES_TG_BIT        = 6;
  localparam int          FES_TL_BIT        = 5;
  localparam int          FES_EW_BIT        = 3;
endpackage : fes_pkg

/* File: fes_cyc_if.sv */
// Interface between sequencer and bus cycle engine
`timescale 1ns/100ps
`default_nettype none
interface fes_cyc_if;
  logic        req;
  logic        wr;
  logic [18:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fes_cyc_if
`default_nettype wire

/* File: fes_cyc_engine.sv */
// Bus cycle engine: one write or read cycle on the flash pins per request
`timescale 1ns/100ps
`default_nettype none
module fes_cyc_engine #(
  parameter int PHASE_CYC = fes_pkg::FES_PHASE_CYC
) (
  input  wire logic  ref_clk,
  input  wire logic  rst_b,
  fes_cyc_if.eng     cyc,
  output logic       ce_b,
  output logic       we_b,
  output logic       oe_b,
  output logic [18:0] addr,
  output logic [7:0] dq_out,
  output logic       dq_oe_b,
  input  wire logic [7:0] dq_in
);
  typedef enum logic [2:0] {
    FES_E_IDLE = 3'b001,
    FES_E_LOW  = 3'b010,
    FES_E_HIGH = 3'b100
  } fes_eng_st_t;
  fes_eng_st_t st_q;
  logic [7:0]  cnt_q;
  logic        tick;
  logic        done_q;
  logic [7:0]  rdata_q;
  assign tick      = (cnt_q == 8'(PHASE_CYC - 1));
  assign cyc.done  = done_q;
  assign cyc.rdata = rdata_q;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= FES_E_IDLE; cnt_q <= 8'h00; done_q <= 1'b0;
      rdata_q <= 8'h00; ce_b <= 1'b1; we_b <= 1'b1; oe_b <= 1'b1;
      addr <= 19'h00000; dq_out <= 8'h00; dq_oe_b <= 1'b1;
    end
    else
    begin
      done_q <= 1'b0;
      unique case (st_q)
        FES_E_IDLE:
          if (cyc.req)
          begin
            // Write: strobe low only with output gate high; address set on the same edge as the fall
            addr <= cyc.addr; dq_out <= cyc.wdata;
            dq_oe_b <= !cyc.wr; oe_b <= cyc.wr; ce_b <= 1'b0;
            we_b <= !cyc.wr; cnt_q <= 8'h00; st_q <= FES_E_LOW;
          end
        FES_E_LOW:
          if (tick)
          begin
            // Rising strobe latches the data; read sample taken here
            we_b <= 1'b1; oe_b <= 1'b1; rdata_q <= dq_in;
            cnt_q <= 8'h00; st_q <= FES_E_HIGH;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        FES_E_HIGH:
          if (tick)
          begin
            ce_b <= 1'b1; dq_oe_b <= 1'b1; done_q <= 1'b1; st_q <= FES_E_IDLE;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        default: st_q <= FES_E_IDLE;
      endcase
    end
  end
endmodule : fes_cyc_engine
`default_nettype wire

/* File: fes_host.sv */
// Host sequencer that drives chip erase, sector erase and status polling on a flash die
`timescale 1ns/100ps
`default_nettype none
module fes_host #(
  parameter int WINDOW_CYC = fes_pkg::FES_WINDOW_CYC,
  parameter int PHASE_CYC  = fes_pkg::FES_PHASE_CYC,
  parameter int SECTORS    = fes_pkg::FES_SECTORS
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             flash_ce_b,
  output logic             flash_we_b,
  output logic             flash_oe_b,
  output logic [18:0]      flash_addr,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe_b,
  input  wire logic [7:0]  flash_dq_in
);
  typedef enum logic [6:0] {
    FES_S_IDLE  = 7'b0000001,
    FES_S_WRITE = 7'b0000010,
    FES_S_WWAIT = 7'b0000100,
    FES_S_EXTRA = 7'b0001000,
    FES_S_POLL  = 7'b0010000,
    FES_S_PWAIT = 7'b0100000,
    FES_S_DONE  = 7'b1000000
  } fes_st_t;

  fes_cyc_if cyc ();
  fes_cyc_engine #(.PHASE_CYC(PHASE_CYC)) u_eng (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .cyc     (cyc),
    .ce_b    (flash_ce_b),
    .we_b    (flash_we_b),
    .oe_b    (flash_oe_b),
    .addr    (flash_addr),
    .dq_out  (flash_dq_out),
    .dq_oe_b (flash_dq_oe_b),
    .dq_in   (flash_dq_in)
  );

  fes_st_t              st_q;
  logic [2:0]           step_q;
  logic                 chip_q;
  logic                 reset_only_q;
  logic [SECTORS-1:0]   sect_q;
  logic [SECTORS-1:0]   left_q;
  logic [31:0]          win_q;
  logic                 busy_q;
  logic                 done_q;
  logic                 fail_q;
  logic                 late_q;
  logic                 prev_tg_q;
  logic                 first_q;
  logic [7:0]           last_q;
  logic [18:0]          poll_addr_q;
  logic                 req_q;
  logic                 wr_q;
  logic [18:0]          a_q;
  logic [7:0]           d_q;

  // Register decode
  wire ctrl_wr   = reg_wr && (reg_addr == fes_pkg::FES_REG_CTRL);
  wire sect_wr   = reg_wr && (reg_addr == fes_pkg::FES_REG_SECT);
  wire go_chip   = ctrl_wr && reg_wdata[0] && !busy_q;
  wire go_sect   = ctrl_wr && reg_wdata[1] && !busy_q && (sect_q != '0);
  wire go_reset  = ctrl_wr && reg_wdata[2] && !busy_q;
  wire clr_done  = ctrl_wr && reg_wdata[3];
  wire win_exp   = (win_q == 32'(WINDOW_CYC));

  // Lowest pending sector for the next extra window write
  logic [2:0] next_idx;
  always_comb
  begin
    next_idx = 3'h0;
    for (int i = SECTORS - 1; i >= 0; i--)
      if (left_q[i])
        next_idx = 3'(i);
  end
  wire [18:0] sect_addr = 19'(next_idx) << fes_pkg::FES_SECT_LSB;

  // Six-write sequence table
  logic [14:0] seq_a;
  logic [7:0]  seq_d;
  always_comb
  begin
    unique case (step_q)
      3'h0, 3'h3: begin seq_a = fes_pkg::FES_UNLOCK_ADDR_A; seq_d = fes_pkg::FES_CODE_UNLOCK_A; end
      3'h1, 3'h4: begin seq_a = fes_pkg::FES_UNLOCK_ADDR_B; seq_d = fes_pkg::FES_CODE_UNLOCK_B; end
      3'h2:       begin seq_a = fes_pkg::FES_UNLOCK_ADDR_A; seq_d = fes_pkg::FES_CODE_SETUP; end
      default:    begin seq_a = fes_pkg::FES_UNLOCK_ADDR_A;
                        seq_d = chip_q ? fes_pkg::FES_CODE_CHIP : fes_pkg::FES_CODE_SECTOR; end
    endcase
  end

  wire [7:0] rd    = cyc.rdata;
  wire       dp    = rd[fes_pkg::FES_DP_BIT];
  wire       tg    = rd[fes_pkg::FES_TG_BIT];
  wire       tl    = rd[fes_pkg::FES_TL_BIT];

  assign cyc.req   = req_q;
  assign cyc.wr    = wr_q;
  assign cyc.addr  = a_q;
  assign cyc.wdata = d_q;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Device itself wakes in read mode, so no command is sent at reset
      st_q <= FES_S_IDLE; step_q <= 3'h0; chip_q <= 1'b0; reset_only_q <= 1'b0;
      sect_q <= '0; left_q <= '0; win_q <= 32'h0; busy_q <= 1'b0; done_q <= 1'b0;
      fail_q <= 1'b0; late_q <= 1'b0; prev_tg_q <= 1'b0; first_q <= 1'b0;
      last_q <= 8'h00; poll_addr_q <= 19'h00000; req_q <= 1'b0; wr_q <= 1'b0;
      a_q <= 19'h00000; d_q <= 8'h00;
    end
    else
    begin
      req_q <= 1'b0;
      if (sect_wr && !busy_q)
        sect_q <= reg_wdata[SECTORS-1:0];
      if (st_q == FES_S_EXTRA || st_q == FES_S_WRITE || st_q == FES_S_WWAIT)
        win_q <= (win_q == 32'(WINDOW_CYC)) ? win_q : win_q + 32'h1;
      unique case (st_q)
        FES_S_IDLE:
        begin
          if (clr_done) begin done_q <= 1'b0; fail_q <= 1'b0; late_q <= 1'b0; end
          if (go_chip || go_sect || go_reset)
          begin
            busy_q <= 1'b1; done_q <= 1'b0; fail_q <= 1'b0; late_q <= 1'b0;
            chip_q <= go_chip; reset_only_q <= go_reset; step_q <= 3'h0;
            left_q <= sect_q; st_q <= FES_S_WRITE;
          end
        end
        FES_S_WRITE:
        begin
          req_q <= 1'b1; wr_q <= 1'b1;
          if (reset_only_q)
          begin
            a_q <= 19'h00000; d_q <= fes_pkg::FES_CODE_RESET;
          end
          else if (step_q == 3'h5 && !chip_q)
          begin
            a_q <= sect_addr; d_q <= fes_pkg::FES_CODE_SECTOR;
            poll_addr_q <= sect_addr;
            left_q[next_idx] <= 1'b0;
          end
          else
          begin
            a_q <= {4'h0, seq_a}; d_q <= seq_d;
          end
          st_q <= FES_S_WWAIT;
        end
        FES_S_WWAIT:
          if (cyc.done)
          begin
            if (reset_only_q)
            begin
              busy_q <= 1'b0; done_q <= 1'b1; st_q <= FES_S_IDLE;
            end
            else if (step_q != 3'h5)
            begin
              step_q <= step_q + 3'h1; st_q <= FES_S_WRITE;
            end
            else
            begin
              // Window timer restarts when each sector code write cycle reports done
              win_q <= 32'h0; first_q <= 1'b1;
              if (chip_q) poll_addr_q <= 19'h00000;
              st_q <= (chip_q || left_q == '0) ? FES_S_POLL : FES_S_EXTRA;
            end
          end
        FES_S_EXTRA:
          // Next sector code only while window still open, else give up the rest
          if (win_exp)
          begin
            late_q <= (left_q != '0); st_q <= FES_S_POLL;
          end
          else
          begin
            step_q <= 3'h5; st_q <= FES_S_WRITE;
          end
        FES_S_POLL:
        begin
          // Only reads while the device erases; no command that could abort it
          req_q <= 1'b1; wr_q <= 1'b0; a_q <= poll_addr_q;
          st_q <= FES_S_PWAIT;
        end
        FES_S_PWAIT:
          if (cyc.done)
          begin
            last_q <= rd; first_q <= 1'b0; prev_tg_q <= tg;
            if (dp || (!first_q && tg == prev_tg_q))
              st_q <= FES_S_DONE;
            else if (tl)
            begin
              // Device stays stuck until the reset command
              fail_q <= 1'b1; busy_q <= 1'b0; st_q <= FES_S_IDLE;
            end
            else
              st_q <= FES_S_POLL;
          end
        FES_S_DONE:
          // Bits below the polling bit may lag, so one more read is taken
          if (!req_q && !cyc.done && !wr_q && first_q)
            st_q <= FES_S_DONE;
          else
          begin
            req_q <= 1'b1; wr_q <= 1'b0; a_q <= poll_addr_q; first_q <= 1'b1;
            st_q <= FES_S_DONE;
            if (cyc.done && first_q)
            begin
              last_q <= rd; busy_q <= 1'b0; done_q <= 1'b1; first_q <= 1'b0;
              req_q <= 1'b0; st_q <= FES_S_IDLE;
            end
            else if (first_q)
              req_q <= 1'b0;
          end
        default: st_q <= FES_S_IDLE;
      endcase
    end
  end

  // Read port: data one cycle after the strobe
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0;
    unique case (reg_addr)
      fes_pkg::FES_REG_SECT: rmux = 32'(sect_q);
      fes_pkg::FES_REG_STAT: rmux = {27'h0, (st_q == FES_S_EXTRA), late_q, fail_q, done_q, busy_q};
      fes_pkg::FES_REG_DATA: rmux = {24'h0, last_q};
      default:               rmux = 32'h0;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rmux : 32'h0;
  end
endmodule : fes_host
`default_nettype wire

/* File: fes_host_assertions.sv */
// Checker on the flash pins of the erase host
`timescale 1ns/100ps
`default_nettype none
module fes_host_assertions (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        flash_ce_b,
  input wire logic        flash_we_b,
  input wire logic        flash_oe_b,
  input wire logic [18:0] flash_addr,
  input wire logic [7:0]  flash_dq_out,
  input wire logic        flash_dq_oe_b
);
  logic        we_q;
  logic [7:0]  last_d_q;
  wire         take  = flash_we_b && !we_q;
  wire  [14:0] low_a = flash_addr[14:0];
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      we_q     <= 1'b1;
      last_d_q <= 8'h00;
    end
    else
    begin
      we_q <= flash_we_b;
      if (take)
        last_d_q <= flash_dq_out;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence wr_low2;
    !flash_we_b ##1 !flash_we_b;
  endsequence
  sequence wr_pulse;
    !flash_we_b [*2] ##1 flash_we_b;
  endsequence
  a_write_gate: assert property (!flash_we_b |-> !flash_ce_b && flash_oe_b)
    else $error("write strobe without select or with gate low");
  a_write_drives: assert property (!flash_we_b |-> !flash_dq_oe_b)
    else $error("data not driven during write");
  a_read_released: assert property (!flash_oe_b |-> flash_dq_oe_b && flash_we_b)
    else $error("data driven while device outputs");
  a_pulse_len: assert property ($fell(flash_we_b) |-> wr_pulse)
    else $error("write strobe length wrong");
  a_latch_stable: assert property (wr_low2 |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved inside write strobe");
  a_unlock_order: assert property (take && flash_dq_out == fes_pkg::FES_CODE_UNLOCK_B
    |-> last_d_q == fes_pkg::FES_CODE_UNLOCK_A && low_a == fes_pkg::FES_UNLOCK_ADDR_B)
    else $error("second unlock out of order");
  a_setup_order: assert property (take && flash_dq_out == fes_pkg::FES_CODE_SETUP
    |-> last_d_q == fes_pkg::FES_CODE_UNLOCK_B && low_a == fes_pkg::FES_UNLOCK_ADDR_A)
    else $error("setup write out of order");
  a_chip_order: assert property (take && flash_dq_out == fes_pkg::FES_CODE_CHIP
    |-> last_d_q == fes_pkg::FES_CODE_UNLOCK_B && low_a == fes_pkg::FES_UNLOCK_ADDR_A)
    else $error("chip erase code out of order");
  a_sector_order: assert property (take && flash_dq_out == fes_pkg::FES_CODE_SECTOR
    |-> last_d_q == fes_pkg::FES_CODE_UNLOCK_B || last_d_q == fes_pkg::FES_CODE_SECTOR)
    else $error("sector code out of order");
  a_reset_idle: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rst_b |-> flash_ce_b && flash_we_b && flash_oe_b)
    else $error("flash pins active in reset");
endmodule : fes_host_assertions
bind fes_host fes_host_assertions u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .flash_ce_b(flash_ce_b), .flash_we_b(flash_we_b), .flash_oe_b(flash_oe_b),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_b(flash_dq_oe_b));
`default_nettype wire

/* File: fes_flash_model.sv */
// Behavioural flash die answering the erase host
`timescale 1ns/100ps
`default_nettype none
module fes_flash_model #(
  parameter int WIN_CYC = 60,
  parameter int RUN_CYC = 200
) (
  input  wire logic        ref_clk,
  input  wire logic        ce_b,
  input  wire logic        we_b,
  input  wire logic        oe_b,
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe_b,
  input  wire logic        tlim,
  input  wire logic        lockout,
  output logic      [7:0]  dq_in,
  output logic      [7:0]  erased_mask = 8'h00
);
  logic armed_q = 1'b0, we_q = 1'b1, oe_q = 1'b1, busy_q = 1'b0, win_q = 1'b0, tog_q = 1'b0;
  logic [2:0]  step_q = 3'h0;
  logic [7:0]  pend_q = 8'h00, last_q = 8'h00;
  logic [18:0] la_q = 19'h0;
  int          cnt_q = 0;
  wire         rd    = !ce_b && !oe_b && we_b;
  wire  [7:0]  stat  = {1'b0, tog_q, tlim && busy_q, 1'b0, !win_q, 3'h0};
  wire  [7:0]  arr   = erased_mask[addr[18:16]] ? 8'hff : 8'h00;
  wire  [7:0]  exp_d = (step_q == 3'h1 || step_q == 3'h4) ? fes_pkg::FES_CODE_UNLOCK_B :
                       (step_q == 3'h2) ? fes_pkg::FES_CODE_SETUP : fes_pkg::FES_CODE_UNLOCK_A;
  wire  [14:0] exp_a = (step_q == 3'h1 || step_q == 3'h4) ? fes_pkg::FES_UNLOCK_ADDR_B :
                       fes_pkg::FES_UNLOCK_ADDR_A;
  // Released bus shows the inverse of its last level so a stale byte never passes
  assign dq_in = !dq_oe_b ? dq_out : (rd ? ((busy_q || win_q) ? stat : arr) : ~last_q);
  always @(posedge ref_clk)
  begin
    we_q   <= we_b;
    oe_q   <= oe_b;
    last_q <= dq_in;
    if (we_b) armed_q <= 1'b1;
    if (!we_b && we_q) la_q <= addr;
    if (oe_b && !oe_q && (busy_q || win_q)) tog_q <= ~tog_q;
    if (win_q && cnt_q == 0) begin win_q <= 1'b0; busy_q <= 1'b1; cnt_q <= RUN_CYC; end
    else if (cnt_q > 0) cnt_q <= cnt_q - 1;
    else if (busy_q && !tlim) begin busy_q <= 1'b0; erased_mask <= erased_mask | pend_q; end
    if (we_b && !we_q && armed_q && !ce_b && oe_b && !lockout)
    begin
      if (dq_out == fes_pkg::FES_CODE_RESET) begin step_q <= 3'h0; busy_q <= 1'b0; win_q <= 1'b0; end
      else if (busy_q) step_q <= 3'h0;
      else if (win_q && dq_out == fes_pkg::FES_CODE_SECTOR)
        begin pend_q <= pend_q | (8'h01 << la_q[18:16]); cnt_q <= WIN_CYC; end
      else if (win_q) begin win_q <= 1'b0; cnt_q <= 0; step_q <= 3'h0; end
      else if (step_q == 3'h5 && dq_out == fes_pkg::FES_CODE_CHIP && la_q[14:0] == exp_a)
        begin step_q <= 3'h0; pend_q <= 8'hff; busy_q <= 1'b1; cnt_q <= RUN_CYC; end
      else if (step_q == 3'h5 && dq_out == fes_pkg::FES_CODE_SECTOR)
        begin step_q <= 3'h0; pend_q <= 8'h01 << la_q[18:16]; win_q <= 1'b1; cnt_q <= WIN_CYC; end
      else step_q <= (dq_out == exp_d && la_q[14:0] == exp_a && step_q < 3'h5) ? step_q + 3'h1 : 3'h0;
    end
    // Supply too low: back to read mode, all activity dropped
    if (lockout) begin step_q <= 3'h0; busy_q <= 1'b0; win_q <= 1'b0; cnt_q <= 0; end
  end
endmodule : fes_flash_model
`default_nettype wire

/* File: flash_erase_and_status_sequencer_test.sv */
// Testbench for the erase host against the flash die model
`timescale 1ns/100ps
`default_nettype none
module flash_erase_and_status_sequencer_test;
  typedef struct packed {logic [3:0] a; logic [31:0] w; logic [31:0] e;} fes_row_t;
  logic ref_clk = 1'b0, rst_b = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tlim = 1'b0;
  logic lockout = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, s;
  logic [31:0] reg_rdata;
  logic        ce_b, we_b, oe_b, dq_oe_b;
  logic [18:0] f_addr;
  logic [7:0]  dq_out, dq_in, mask;
  int fails = 0, samples_checked = 0;
  fes_row_t rows [5] = '{'{4'h1, 32'h01, 32'h01}, '{4'h1, 32'h80, 32'h80},
    '{4'h1, 32'h5a, 32'h5a}, '{4'h1, 32'h24, 32'h24}, '{4'h9, 32'h33, 32'h00}};
  fes_host #(.WINDOW_CYC(50)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_ce_b(ce_b), .flash_we_b(we_b), .flash_oe_b(oe_b), .flash_addr(f_addr),
    .flash_dq_out(dq_out), .flash_dq_oe_b(dq_oe_b), .flash_dq_in(dq_in));
  fes_flash_model u_flash (.ref_clk(ref_clk), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b),
    .addr(f_addr), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .tlim(tlim), .lockout(lockout),
    .dq_in(dq_in),
    .erased_mask(mask));
  initial forever #5 ref_clk = ~ref_clk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_read
  // Bounded poll of the busy bit; a hang here counts as a mismatch
  task run_op(input logic [31:0] go);
    reg_write(fes_pkg::FES_REG_CTRL, 32'h8);
    reg_write(fes_pkg::FES_REG_CTRL, go);
    for (int i = 0; i < 2000; i++)
    begin
      reg_read(fes_pkg::FES_REG_STAT, s);
      if (s[0] === 1'b0) break;
    end
    if (s[0] !== 1'b0) fails++;
  endtask : run_op
  task summarize;
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial
  begin
    #100000;
    fails++;
    summarize();
  end
  initial
  begin
    // Falling edge at time zero so the pins are reset before the first clock edge
    rst_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    reg_read(fes_pkg::FES_REG_STAT, s);
    check(s, 32'h0);
    foreach (rows[i])
    begin
      reg_write(rows[i].a, rows[i].w);
      reg_read(rows[i].a, s);
      check(s, rows[i].e);
    end
    // Die in supply lockout ignores the erase; toggle stops so the host finishes
    lockout <= 1'b1;
    run_op(32'h1);
    check(s & 32'h7, 32'h2);
    check({24'h0, mask}, 32'h00);
    reg_read(fes_pkg::FES_REG_DATA, s);
    check(s, 32'h00);
    lockout <= 1'b0;
    run_op(32'h2);
    check(s & 32'h7, 32'h2);
    check({24'h0, mask}, 32'h24);
    reg_read(fes_pkg::FES_REG_DATA, s);
    check(s, 32'hff);
    run_op(32'h1);
    check({24'h0, mask}, 32'hff);
    tlim <= 1'b1;
    run_op(32'h1);
    check(s & 32'h7, 32'h4);
    run_op(32'h4);
    check(s & 32'h7, 32'h2);
    tlim <= 1'b0;
    run_op(32'h1);
    check(s & 32'h7, 32'h2);
    reg_read(fes_pkg::FES_REG_DATA, s);
    check(s, 32'hff);
    summarize();
  end
endmodule : flash_erase_and_status_sequencer_test
`default_nettype wire
